// ==== src/pwmirq_pkg.sv ====
// Package for the PWM interrupt status block: register offsets, bit layout, reset values.
// Assumes a 32-bit APB register bus with byte addresses on paddr.
package pwmirq_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] PWMIRQ_ENABLE_OFS = 12'h110;
   localparam logic [11:0] PWMIRQ_RAW_OFS    = 12'h114;
   localparam logic [11:0] PWMIRQ_MASKED_OFS = 12'h118;
   localparam logic [11:0] PWMIRQ_CLEAR_OFS  = 12'h11c;

   // ------------------------------------------------------------
   // Bit layout of the raw, masked, enable and clear registers
   // ------------------------------------------------------------
   localparam int PWMIRQ_NUM_EVT     = 30;
   localparam int PWMIRQ_TIMER_STOP  = 0;
   localparam int PWMIRQ_TIMER_ZERO  = 3;
   localparam int PWMIRQ_TIMER_PER   = 6;
   localparam int PWMIRQ_FAULT_START = 9;
   localparam int PWMIRQ_FAULT_END   = 12;
   localparam int PWMIRQ_OP_CMP_A    = 15;
   localparam int PWMIRQ_OP_CMP_B    = 18;
   localparam int PWMIRQ_CYC_TRIP    = 21;
   localparam int PWMIRQ_ONE_SHOT    = 24;
   localparam int PWMIRQ_CAPTURE     = 27;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [PWMIRQ_NUM_EVT-1:0] PWMIRQ_FLAGS_RST  = 30'h0000_0000;
   localparam logic [PWMIRQ_NUM_EVT-1:0] PWMIRQ_ENABLE_RST = 30'h0000_0000;
   localparam logic [31:0]               PWMIRQ_RDATA_RST  = 32'h0000_0000;

   typedef logic [PWMIRQ_NUM_EVT-1:0] pwmirq_vec_t;

endpackage : pwmirq_pkg

// ==== src/pwmirq_flags.sv ====
// Sticky event flag bank: one flag per event source, set by hardware, cleared by software.
// Assumes event pulses and clear strobes are synchronous to pclk.
`timescale 1ns/10ps
module pwmirq_flags #(
   parameter int WIDTH = 30
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Events and clears
   input  wire logic [WIDTH-1:0] set_pulse,
   input  wire logic [WIDTH-1:0] clr_pulse,
   // Flag state
   output logic      [WIDTH-1:0] flags_q
);

   // Refuse an empty flag bank at elaboration
   if (WIDTH < 1) begin : g_bad_width
      $error("pwmirq_flags: WIDTH must be at least 1");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~clr_pulse) | set_pulse;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      (|set_pulse) |=> ((flags_q & $past(set_pulse)) == $past(set_pulse));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      (clr_pulse == '0) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

   property p_clear_only;
      @(posedge pclk) disable iff (!presetn)
      (set_pulse == '0) |=> (flags_q == ($past(flags_q) & ~$past(clr_pulse)));
   endproperty
   a_clear_only: assert property (p_clear_only) else $error("clear result wrong");

endmodule : pwmirq_flags

// ==== src/pwmirq_top.sv ====
// Top of the PWM interrupt status block: APB slave, enable register, flag bank, irq output.
// Assumes one-cycle event pulses from the timers, operators, fault handlers and capture units.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps

// Notes on behaviour
// - Capture channel flags, three channels
// - One-shot trip flags per PWM output
// - Cycle trip flags per PWM output
// - Operator compare A flags, operators 0-2
// - Operator compare B flags, operators 0-2
// - Fault start and end flags each
// - Timer period flags, timers 0-2
// - Timer zero flags, timers 0-2
// - Timer stop flags, timers 0-2
// - Masked status register, read-only view
// - Write one clears flag, zeros ignored
// - Enable bit gates each masked bit
module pwmirq_top
   import pwmirq_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Event pulses, one bit per unit
   input  wire logic [2:0]        capture_event,
   input  wire logic [2:0]        one_shot_trip,
   input  wire logic [2:0]        cycle_trip,
   input  wire logic [2:0]        operator_compare_a_event,
   input  wire logic [2:0]        operator_compare_b_event,
   input  wire logic [2:0]        fault_start_event,
   input  wire logic [2:0]        fault_end_event,
   input  wire logic [2:0]        timer_period_event,
   input  wire logic [2:0]        timer_zero_event,
   input  wire logic [2:0]        timer_stop_event,
   // Interrupt
   output logic                   irq_q
);
   import pwmirq_pkg::*;

   // Refuse an address bus too narrow for the register map
   if (ADDR_W < 12) begin : g_bad_addr_w
      $error("pwmirq_top: ADDR_W must be at least 12");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      addr_hit = (a == ADDR_W'(ofs));
   endfunction : addr_hit

   function automatic pwmirq_vec_t lane_mask(input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      lane_mask = m[PWMIRQ_NUM_EVT-1:0];
   endfunction : lane_mask

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic        access;
   logic        wr_en;
   logic        rd_en;
   logic        hit_ena;
   logic        hit_raw;
   logic        hit_msk;
   logic        hit_clr;
   logic        mapped;

   assign access  = psel && penable;
   assign wr_en   = access && pwrite;
   assign rd_en   = access && !pwrite;
   assign hit_ena = addr_hit(paddr, PWMIRQ_ENABLE_OFS);
   assign hit_raw = addr_hit(paddr, PWMIRQ_RAW_OFS);
   assign hit_msk = addr_hit(paddr, PWMIRQ_MASKED_OFS);
   assign hit_clr = addr_hit(paddr, PWMIRQ_CLEAR_OFS);
   assign mapped  = hit_ena || hit_raw || hit_msk || hit_clr;

   // ------------------------------------------------------------
   // Event vector
   // ------------------------------------------------------------
   pwmirq_vec_t evt_set;
   pwmirq_vec_t clr_strobe;
   pwmirq_vec_t raw_flags;
   pwmirq_vec_t enable_q;
   pwmirq_vec_t enable_d;
   pwmirq_vec_t masked;

   always_comb begin
      evt_set = '0;
      evt_set[PWMIRQ_TIMER_STOP  +: 3] = timer_stop_event;
      evt_set[PWMIRQ_TIMER_ZERO  +: 3] = timer_zero_event;
      evt_set[PWMIRQ_TIMER_PER   +: 3] = timer_period_event;
      evt_set[PWMIRQ_FAULT_START +: 3] = fault_start_event;
      evt_set[PWMIRQ_FAULT_END   +: 3] = fault_end_event;
      evt_set[PWMIRQ_OP_CMP_A    +: 3] = operator_compare_a_event;
      evt_set[PWMIRQ_OP_CMP_B    +: 3] = operator_compare_b_event;
      evt_set[PWMIRQ_CYC_TRIP    +: 3] = cycle_trip;
      evt_set[PWMIRQ_ONE_SHOT    +: 3] = one_shot_trip;
      evt_set[PWMIRQ_CAPTURE     +: 3] = capture_event;
   end

   // Ones in clear word clear flags
   assign clr_strobe = (wr_en && hit_clr) ? (pwdata[PWMIRQ_NUM_EVT-1:0] & lane_mask(pstrb)) : '0;

   pwmirq_flags #(
      .WIDTH     (PWMIRQ_NUM_EVT)
   ) u_flags (
      .pclk      (pclk),
      .presetn   (presetn),
      .set_pulse (evt_set),
      .clr_pulse (clr_strobe),
      .flags_q   (raw_flags)
   );

   // ------------------------------------------------------------
   // Enable register
   // ------------------------------------------------------------
   // Writable enable per source
   always_comb begin
      enable_d = enable_q;
      if (wr_en && hit_ena) begin
         enable_d = (enable_q & ~lane_mask(pstrb)) | (pwdata[PWMIRQ_NUM_EVT-1:0] & lane_mask(pstrb));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= PWMIRQ_ENABLE_RST;
      end else begin
         enable_q <= enable_d;
      end
   end

   assign masked = raw_flags & enable_q;

   // ------------------------------------------------------------
   // Read data and response
   // ------------------------------------------------------------
   // Read back raw and masked views
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= PWMIRQ_RDATA_RST;
      end else if (psel && !penable && !pwrite) begin
         if (hit_ena) begin
            prdata <= {2'h0, enable_q};
         end else if (hit_raw) begin
            prdata <= {2'h0, raw_flags};
         end else if (hit_msk) begin
            prdata <= {2'h0, masked};
         end else begin
            prdata <= PWMIRQ_RDATA_RST;
         end
      end
   end

   // Ready in the first cycle of the access phase, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // Error on unmapped address or write to a read-only register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && (!mapped || (pwrite && (hit_raw || hit_msk)));
      end
   end

   // ------------------------------------------------------------
   // Interrupt output
   // ------------------------------------------------------------
   // OR of masked bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         // Next flags and next enables, so the output never lags the masked view
         irq_q <= |(((raw_flags & ~clr_strobe) | evt_set) & enable_d);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_irq_follows;
      @(posedge pclk) disable iff (!presetn)
      ##1 (irq_q == |masked);
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq does not match masked flags");

   property p_capture_sets;
      @(posedge pclk) disable iff (!presetn)
      capture_event[0] |=> raw_flags[PWMIRQ_CAPTURE];
   endproperty
   a_capture_sets: assert property (p_capture_sets) else $error("capture flag not set");

   property p_one_shot_sets;
      @(posedge pclk) disable iff (!presetn)
      one_shot_trip[2] |=> raw_flags[PWMIRQ_ONE_SHOT + 2];
   endproperty
   a_one_shot_sets: assert property (p_one_shot_sets) else $error("one-shot flag not set");

   property p_cycle_sets;
      @(posedge pclk) disable iff (!presetn)
      cycle_trip[1] |=> raw_flags[PWMIRQ_CYC_TRIP + 1];
   endproperty
   a_cycle_sets: assert property (p_cycle_sets) else $error("cycle trip flag not set");

   property p_cmp_sets;
      @(posedge pclk) disable iff (!presetn)
      (operator_compare_a_event[0] && operator_compare_b_event[2])
         |=> (raw_flags[PWMIRQ_OP_CMP_A] && raw_flags[PWMIRQ_OP_CMP_B + 2]);
   endproperty
   a_cmp_sets: assert property (p_cmp_sets) else $error("compare flag not set");

   property p_fault_sets;
      @(posedge pclk) disable iff (!presetn)
      (fault_start_event[1] && fault_end_event[0])
         |=> (raw_flags[PWMIRQ_FAULT_START + 1] && raw_flags[PWMIRQ_FAULT_END]);
   endproperty
   a_fault_sets: assert property (p_fault_sets) else $error("fault flag not set");

   property p_timer_sets;
      @(posedge pclk) disable iff (!presetn)
      (timer_period_event[2] && timer_zero_event[1] && timer_stop_event[0])
         |=> (raw_flags[PWMIRQ_TIMER_PER + 2] && raw_flags[PWMIRQ_TIMER_ZERO + 1]
              && raw_flags[PWMIRQ_TIMER_STOP]);
   endproperty
   a_timer_sets: assert property (p_timer_sets) else $error("timer flag not set");

   property p_masked_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_msk) |=> (prdata == {2'h0, $past(masked)});
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("masked read wrong");

   property p_ready_once;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready timing wrong");

   property p_ro_write_err;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && pwrite && (hit_raw || hit_msk)) |=> (pready && pslverr);
   endproperty
   a_ro_write_err: assert property (p_ro_write_err) else $error("write to read-only view not refused");

   property p_clear_lands;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_clr && (evt_set == '0)) |=> ((raw_flags & $past(clr_strobe)) == '0);
   endproperty
   a_clear_lands: assert property (p_clear_lands) else $error("cleared flag still set");

   property p_zero_kept;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_clr && (evt_set == '0))
         |=> ((raw_flags & ~$past(clr_strobe)) == ($past(raw_flags) & ~$past(clr_strobe)));
   endproperty
   a_zero_kept: assert property (p_zero_kept) else $error("flag cleared by a zero bit");

   property p_enable_hold;
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && hit_ena) |=> $stable(enable_q);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enable changed without a write");

   c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) !irq_q ##1 irq_q);
   c_clear_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_clr && (|raw_flags));
   c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn) |(evt_set & clr_strobe));
   c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
   c_enable_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_ena);

endmodule : pwmirq_top

// ==== testbench/tb_pwm_interrupt_status.sv ====
// Self-checking bench for the PWM interrupt status block, driven over APB.
// Assumes the pwmirq_pkg layout and a 40 MHz pclk with async active-low reset.
`timescale 1ns/10ps
module tb_pwm_interrupt_status;
   import pwmirq_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_q, errv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0]  pstrb;
   pwmirq_vec_t ev;
   int          n_fail, total_checks;

   always #12.5 pclk = ~pclk;

   pwmirq_top dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr),
      .capture_event(ev[PWMIRQ_CAPTURE +: 3]), .one_shot_trip(ev[PWMIRQ_ONE_SHOT +: 3]),
      .cycle_trip(ev[PWMIRQ_CYC_TRIP +: 3]),
      .operator_compare_a_event(ev[PWMIRQ_OP_CMP_A +: 3]),
      .operator_compare_b_event(ev[PWMIRQ_OP_CMP_B +: 3]),
      .fault_start_event(ev[PWMIRQ_FAULT_START +: 3]), .fault_end_event(ev[PWMIRQ_FAULT_END +: 3]),
      .timer_period_event(ev[PWMIRQ_TIMER_PER +: 3]), .timer_zero_event(ev[PWMIRQ_TIMER_ZERO +: 3]),
      .timer_stop_event(ev[PWMIRQ_TIMER_STOP +: 3]), .irq_q(irq_q)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         $display("BAD %0t apb transfer never completed", $time);
         close_out();
      end else begin
         rdv = prdata;
         errv = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic pulse(input pwmirq_vec_t v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= '0;
   endtask : pulse

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      ev = '0;
      n_fail = 0;
      total_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and clear register reads zero
      apb(1'b0, PWMIRQ_ENABLE_OFS, 32'h0); check(rdv, 32'h0, "enable rst");
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h0, "raw rst");
      apb(1'b0, PWMIRQ_MASKED_OFS, 32'h0); check(rdv, 32'h0, "masked rst");
      apb(1'b0, PWMIRQ_CLEAR_OFS, 32'h0);  check({rdv[31:1], errv}, 32'h0, "clear read");
      // Every source sets its own flag and is cleared alone
      for (int b = 0; b < PWMIRQ_NUM_EVT; b++) begin
         pulse(pwmirq_vec_t'(1) << b);
         apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h1 << b, "raw set");
         apb(1'b0, PWMIRQ_MASKED_OFS, 32'h0); check(rdv, 32'h0, "masked off");
         check({31'h0, irq_q}, 32'h0, "irq off");
         apb(1'b1, PWMIRQ_CLEAR_OFS, 32'h1 << b);
         apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h0, "raw clr");
      end
      // Enable gating and interrupt output
      apb(1'b1, PWMIRQ_ENABLE_OFS, 32'hffff_ffff); check({31'h0, errv}, 32'h0, "enable err");
      apb(1'b0, PWMIRQ_ENABLE_OFS, 32'h0); check(rdv, 32'h3fff_ffff, "enable rb");
      pulse('1);
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h3fff_ffff, "raw all");
      apb(1'b1, PWMIRQ_ENABLE_OFS, 32'h2000_0001);
      apb(1'b0, PWMIRQ_MASKED_OFS, 32'h0); check(rdv, 32'h2000_0001, "masked part");
      check({31'h0, irq_q}, 32'h1, "irq on");
      apb(1'b1, PWMIRQ_CLEAR_OFS, 32'h0000_0001);
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h3fff_fffe, "zero bits kept");
      apb(1'b1, PWMIRQ_CLEAR_OFS, 32'hffff_ffff, 4'b0001);
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h3fff_ff00, "strobe clr");
      apb(1'b0, PWMIRQ_MASKED_OFS, 32'h0); check(rdv, 32'h2000_0000, "masked left");
      check({31'h0, irq_q}, 32'h1, "irq still");
      apb(1'b1, PWMIRQ_CLEAR_OFS, 32'h2000_0000);
      repeat (2) @(posedge pclk);
      check({31'h0, irq_q}, 32'h0, "irq fell");
      apb(1'b1, PWMIRQ_CLEAR_OFS, 32'hffff_ffff);
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h0, "raw empty");
      // Event held across a clear of the same flag
      @(posedge pclk);
      ev <= pwmirq_vec_t'(1) << (PWMIRQ_CAPTURE + 2);
      apb(1'b1, PWMIRQ_CLEAR_OFS, 32'h2000_0000);
      ev <= '0;
      repeat (20) @(posedge pclk);
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h2000_0000, "set wins");
      // Read-only and unmapped places
      apb(1'b1, PWMIRQ_RAW_OFS, 32'hffff_ffff);    check({31'h0, errv}, 32'h1, "raw ro err");
      apb(1'b1, PWMIRQ_MASKED_OFS, 32'hffff_ffff); check({31'h0, errv}, 32'h1, "masked ro err");
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h2000_0000, "raw kept");
      apb(1'b0, PWMIRQ_ENABLE_OFS, 32'h0); check(rdv, 32'h2000_0001, "enable kept");
      apb(1'b0, 12'h120, 32'h0);           check({rdv[31:1], errv}, 32'h1, "unmapped");
      check({31'h0, irq_q}, 32'h1, "irq capture");
      // Reset in mid-run drops flags, enables and the interrupt
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check({31'h0, irq_q}, 32'h0, "irq rst");
      presetn <= 1'b1;
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h0, "raw rst again");
      apb(1'b0, PWMIRQ_ENABLE_OFS, 32'h0); check(rdv, 32'h0, "enable rst again");
      pulse(pwmirq_vec_t'(1) << PWMIRQ_TIMER_STOP);
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h1, "raw after rst");
      apb(1'b1, PWMIRQ_CLEAR_OFS, 32'hffff_ffff);
      apb(1'b0, PWMIRQ_RAW_OFS, 32'h0);    check(rdv, 32'h0, "all clear");
      check({31'h0, irq_q}, 32'h0, "irq idle");
      close_out();
   end

endmodule : tb_pwm_interrupt_status
